// >>> hdl/mio_pin_sync.sv
/*
 * three-stage synchroniser for pin inputs; a bit changes only once
 * the second and third stages agree.
 * assumes: one clock, asynchronous active-low reset.
 */
`timescale 1ns/100ps

module mio_pin_sync #(
	parameter int WIDTH = 8
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] stage1; // read only by stage2
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	// refuse a width the logic cannot serve
	if (WIDTH < 1) begin : g_chk
		$error("mio_pin_sync: WIDTH must be at least 1");
	end

	//////////////////////////////////////////////////////////////////
	// shift chain
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else begin
			stage1 <= din;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// accept a bit only when two stages agree, filtering one-cycle glitches
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			dout <= '0;
		end else begin
			dout <= (stage2 & stage3) | (dout & (stage2 ^ stage3));
		end
	end

endmodule

// >>> hdl/mio_ports.sv
/*
 * general-purpose logic of four ports: address-capable port, control
 * strobe port, three-bit select port and analog-shared input port.
 * assumes: register port driven on mclk, strobes one cycle long;
 * pin inputs are asynchronous; cpu address and strobes and the
 * select lines come from logic on mclk.
 */
// Operation
// - reset clears address port latch, direction, function
// - input-mode latch bit switches pull-down, 1 off
// - function/direction pick input, output, low, high address
// - strobe bits output-only, reset high, others pulled-up
// - read strobe with latch 0: every access
// - read strobe with latch 1: external accesses only
// - romless variant forces read and write strobes
// - reset sets select bits 0,1 high, pulled-up
// - reset clears select bit 2, configuration, pull-down
// - select bits may carry active-low area strobes
// - analog-shared port is read-only pin levels
`timescale 1ns/100ps

`include "mio_consts.svh"

module mio_ports
	import mio_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	input mio_busreq_t busReq,
	output logic [7:0] rdData,
	input wire logic [23:0] cpuAddr,
	input wire logic cpuRdN,
	input wire logic cpuWrN,
	input wire logic extAccess,
	input wire logic [2:0] areaSelectN,
	input wire logic [7:2] ctrlAltOut,
	input wire logic romlessPin,
	input wire logic [7:0] addrPortIn,
	output logic [7:0] addrPortOut,
	output logic [7:0] addrPortOeN,
	output logic [7:0] addrPortPullDown,
	input wire logic [7:0] ctrlPortIn,
	output logic [7:0] ctrlPortOut,
	output logic [7:0] ctrlPortOeN,
	output logic [7:0] ctrlPortPullUp,
	input wire logic [2:0] selPortIn,
	output logic [2:0] selPortOut,
	output logic [2:0] selPortOeN,
	output logic [1:0] selPortPullUp,
	output logic selPortPullDown,
	input wire logic [7:0] analogPortIn
);

	//////////////////////////////////////////////////////////////////
	// functions

	// decode one address-port bit into its mode
	function automatic mio_amode_e_t addrMode(input logic f, input logic d);
		mio_amode_e_t m;
		m = AM_INPUT;
		unique case ({f, d})
			2'b00: m = AM_INPUT;
			2'b01: m = AM_OUTPUT;
			2'b10: m = AM_LOW_ADDR;
			2'b11: m = AM_HIGH_ADDR;
		endcase
		return m;
	endfunction

	// write strobe aimed at one offset
	function automatic logic wrHit(input mio_busreq_t r, input logic [7:0] off);
		return r.wr && (r.addr == off);
	endfunction

	// data read value: pin where input, latch where driven
	function automatic logic [7:0] portRead(input logic [7:0] pin,
			input logic [7:0] lat, input logic [7:0] drv);
		return (drv & lat) | (~drv & pin);
	endfunction

	//////////////////////////////////////////////////////////////////
	// state

	logic [7:0] addressPortLatch; // also pull-down control
	logic [7:0] addressPortDirection; // write-only
	logic [7:0] addressPortFunction; // write-only
	logic [7:0] controlPortLatch; // bit 0 is the read pin latch
	logic [7:0] controlPortDirection; // bits 0,1 unused
	logic [7:0] controlPortFunction; // bit 0 is the read strobe select
	logic [2:0] selectPortLatch;
	logic [2:0] selectPortDirection;
	logic [2:0] selectPortFunction;
	logic readPinLatch;
	logic readStrobeSelect;

	// synchronised pins
	logic [7:0] addrSync;
	logic [7:0] ctrlSync;
	logic [2:0] selSync;
	logic [7:0] analogPortInput;
	logic romless;

	// next pin values, registered onto the outputs
	logic [7:0] next_addrPortOut;
	logic [7:0] next_addrPortOeN;
	logic [7:0] next_ctrlPortOut;
	logic [7:0] next_ctrlPortOeN;
	logic [2:0] next_selPortOut;
	logic [2:0] next_selPortOeN;
	logic [7:0] next_rdData;

	// drive masks used for data reads
	logic [7:0] addrDrive;
	logic [7:0] ctrlDrive;
	logic [7:0] selDrive;

	assign readPinLatch = controlPortLatch[`MIO_RD_BIT];
	assign readStrobeSelect = controlPortFunction[`MIO_RD_BIT];

	//////////////////////////////////////////////////////////////////
	// pin synchroniser, one 28-bit instance for all asynchronous inputs
	mio_pin_sync #(
		.WIDTH(28)
	) u_sync (
		.mclk(mclk),
		.rstn(rstn),
		.din({romlessPin, analogPortIn, selPortIn, ctrlPortIn, addrPortIn}),
		.dout({romless, analogPortInput, selSync, ctrlSync, addrSync})
	);

	//////////////////////////////////////////////////////////////////
	// address port registers
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			addressPortLatch <= `MIO_RST_ADDR_LATCH;
			addressPortDirection <= `MIO_RST_CFG8;
			addressPortFunction <= `MIO_RST_CFG8;
		end else begin
			// the ordering of direction before function is left to software
			if (wrHit(busReq, `MIO_OFF_ADDR_LATCH)) begin
				addressPortLatch <= busReq.wdata;
			end
			if (wrHit(busReq, `MIO_OFF_ADDR_DIR)) begin
				addressPortDirection <= busReq.wdata;
			end
			if (wrHit(busReq, `MIO_OFF_ADDR_FUNC)) begin
				addressPortFunction <= busReq.wdata;
			end
		end
	end

	// control port registers
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			controlPortLatch <= `MIO_RST_CTRL_LATCH;
			controlPortDirection <= `MIO_RST_CFG8;
			controlPortFunction <= `MIO_RST_CFG8;
		end else begin
			if (wrHit(busReq, `MIO_OFF_CTRL_LATCH)) begin
				controlPortLatch <= busReq.wdata;
			end
			if (wrHit(busReq, `MIO_OFF_CTRL_DIR)) begin
				controlPortDirection <= busReq.wdata;
			end
			if (wrHit(busReq, `MIO_OFF_CTRL_FUNC)) begin
				controlPortFunction <= busReq.wdata;
			end
		end
	end

	// select port registers
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			selectPortLatch <= `MIO_RST_SEL_LATCH;
			selectPortDirection <= `MIO_RST_CFG3;
			selectPortFunction <= `MIO_RST_CFG3;
		end else begin
			if (wrHit(busReq, `MIO_OFF_SEL_LATCH)) begin
				selectPortLatch <= busReq.wdata[2:0];
			end
			if (wrHit(busReq, `MIO_OFF_SEL_DIR)) begin
				selectPortDirection <= busReq.wdata[2:0];
			end
			if (wrHit(busReq, `MIO_OFF_SEL_FUNC)) begin
				selectPortFunction <= busReq.wdata[2:0];
			end
		end
	end

	//////////////////////////////////////////////////////////////////
	// address port pin mux
	always_comb begin
		next_addrPortOut = addressPortLatch;
		next_addrPortOeN = 8'hff;
		for (int i = 0; i < 8; i++) begin
			unique case (addrMode(addressPortFunction[i], addressPortDirection[i]))
				AM_INPUT: begin
					next_addrPortOeN[i] = 1'b1;
				end
				AM_OUTPUT: begin
					next_addrPortOeN[i] = 1'b0;
				end
				AM_LOW_ADDR: begin
					next_addrPortOut[i] = cpuAddr[i];
					next_addrPortOeN[i] = 1'b0;
				end
				AM_HIGH_ADDR: begin
					next_addrPortOut[i] = cpuAddr[`MIO_HIGH_ADDR_LSB + i];
					next_addrPortOeN[i] = 1'b0;
				end
			endcase
		end
	end

	// control port pin mux; bits 0 and 1 are always driven
	always_comb begin
		next_ctrlPortOut = controlPortLatch;
		next_ctrlPortOeN = ~controlPortDirection;
		next_ctrlPortOeN[1:0] = 2'b00;
		// read strobe: latch 0 widens it to internal accesses too
		if (readStrobeSelect || romless) begin
			next_ctrlPortOut[`MIO_RD_BIT] = (!readPinLatch || extAccess) ? cpuRdN : 1'b1;
		end
		if (controlPortFunction[`MIO_WR_BIT] || romless) begin
			next_ctrlPortOut[`MIO_WR_BIT] = cpuWrN;
		end
		// upper bits carry the core's control outputs in function mode
		for (int i = 2; i < 8; i++) begin
			if (controlPortFunction[i]) begin
				next_ctrlPortOut[i] = ctrlAltOut[i];
			end
		end
	end

	// select port pin mux
	always_comb begin
		next_selPortOut = selectPortLatch;
		next_selPortOeN = ~(selectPortDirection | selectPortFunction);
		for (int i = 0; i < 3; i++) begin
			if (selectPortFunction[i]) begin
				next_selPortOut[i] = areaSelectN[i];
			end
		end
	end

	//////////////////////////////////////////////////////////////////
	// address port outputs
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			addrPortOut <= `MIO_RST_ADDR_LATCH;
			addrPortOeN <= 8'hff;
			addrPortPullDown <= 8'hff;
		end else begin
			addrPortOut <= next_addrPortOut;
			addrPortOeN <= next_addrPortOeN;
			// latch 1 switches the pull-down off, also in address mode
			addrPortPullDown <= ~addressPortLatch;
		end
	end

	// control port outputs
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ctrlPortOut <= `MIO_RST_CTRL_LATCH;
			ctrlPortOeN <= 8'hfc;
			ctrlPortPullUp <= 8'hfc;
		end else begin
			ctrlPortOut <= next_ctrlPortOut;
			ctrlPortOeN <= next_ctrlPortOeN;
			// pull-ups only on undriven bits with latch 1
			ctrlPortPullUp <= {controlPortLatch[7:2] & ~controlPortDirection[7:2], 2'b00};
		end
	end

	// select port outputs
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			selPortOut <= `MIO_RST_SEL_LATCH;
			selPortOeN <= 3'h7;
			selPortPullUp <= 2'h3;
			selPortPullDown <= 1'b1;
		end else begin
			selPortOut <= next_selPortOut;
			selPortOeN <= next_selPortOeN;
			selPortPullUp <= selectPortLatch[1:0] & next_selPortOeN[1:0];
			selPortPullDown <= ~selectPortLatch[2] & next_selPortOeN[2];
		end
	end

	//////////////////////////////////////////////////////////////////
	// read path; write-only configuration reads as zero
	assign addrDrive = addressPortDirection | addressPortFunction;
	assign ctrlDrive = {controlPortDirection[7:2], 2'b11};
	assign selDrive = {5'h00, selectPortDirection | selectPortFunction};

	always_comb begin
		unique case (busReq.addr)
			`MIO_OFF_ADDR_LATCH: begin
				next_rdData = portRead(addrSync, addressPortLatch, addrDrive);
			end
			`MIO_OFF_CTRL_LATCH: begin
				next_rdData = portRead(ctrlSync, controlPortLatch, ctrlDrive);
			end
			`MIO_OFF_SEL_LATCH: begin
				// absent upper pins have no latch or level, so they read fixed ones
				next_rdData = {`MIO_SEL_UNUSED, 3'h0}
					| portRead({5'h00, selSync}, {5'h00, selectPortLatch}, selDrive);
			end
			`MIO_OFF_ANALOG: begin
				next_rdData = analogPortInput;
			end
			default: begin
				next_rdData = `MIO_RST_RDATA;
			end
		endcase
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rdData <= `MIO_RST_RDATA;
		end else begin
			rdData <= busReq.rd ? next_rdData : `MIO_RST_RDATA;
		end
	end

	//////////////////////////////////////////////////////////////////
	// assertion helpers: has a port been configured since reset
	logic addrTouched;
	logic selTouched;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			addrTouched <= 1'b0;
			selTouched <= 1'b0;
		end else begin
			if (wrHit(busReq, `MIO_OFF_ADDR_LATCH) || wrHit(busReq, `MIO_OFF_ADDR_DIR)
					|| wrHit(busReq, `MIO_OFF_ADDR_FUNC)) begin
				addrTouched <= 1'b1;
			end
			if (wrHit(busReq, `MIO_OFF_SEL_LATCH) || wrHit(busReq, `MIO_OFF_SEL_DIR)
					|| wrHit(busReq, `MIO_OFF_SEL_FUNC)) begin
				selTouched <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);

	// an untouched address port stays cleared, undriven and pulled down
	property p_addrReset;
		!addrTouched |-> addressPortLatch == 8'h00 && addressPortDirection == 8'h00
			&& addressPortFunction == 8'h00 && addrPortOeN == 8'hff
			&& addrPortPullDown == 8'hff;
	endproperty
	a_addrReset: assert property (p_addrReset)
		else $error("address port left its reset state unprompted");

	// a latch write reaches the pull-down two cycles later
	sequence s_latchWrite;
		busReq.wr && busReq.addr == `MIO_OFF_ADDR_LATCH;
	endsequence
	property p_pullDown;
		s_latchWrite |-> ##2 addrPortPullDown == ~$past(busReq.wdata, 2);
	endproperty
	a_pullDown: assert property (p_pullDown)
		else $error("pull-down does not follow the written latch");

	// high address mode drives the upper address line
	property p_highAddr;
		addressPortFunction[0] && addressPortDirection[0]
			|=> addrPortOut[0] == $past(cpuAddr[16]) && !addrPortOeN[0];
	endproperty
	a_highAddr: assert property (p_highAddr)
		else $error("high address not on the pin");

	// low address mode drives the lower address line
	property p_lowAddr;
		addressPortFunction[7] && !addressPortDirection[7]
			|=> addrPortOut[7] == $past(cpuAddr[7]) && !addrPortOeN[7];
	endproperty
	a_lowAddr: assert property (p_lowAddr)
		else $error("low address not on the pin");

	// strobe bits are always driven and never pulled
	property p_strobeDriven;
		ctrlPortOeN[1:0] == 2'b00 && ctrlPortPullUp[1:0] == 2'b00;
	endproperty
	a_strobeDriven: assert property (p_strobeDriven)
		else $error("strobe bit released");

	// latch 0: read strobe passes for every access
	property p_rdAlways;
		readStrobeSelect && !readPinLatch |=> ctrlPortOut[0] == $past(cpuRdN);
	endproperty
	a_rdAlways: assert property (p_rdAlways)
		else $error("read strobe missing for an access");

	// latch 1: internal accesses keep the read strobe high
	property p_rdExtOnly;
		(readStrobeSelect || romless) && readPinLatch && !extAccess |=> ctrlPortOut[0];
	endproperty
	a_rdExtOnly: assert property (p_rdExtOnly)
		else $error("read strobe on an internal access");

	// romless variant carries the write strobe whatever the function bit
	property p_romless;
		romless |=> ctrlPortOut[1] == $past(cpuWrN);
	endproperty
	a_romless: assert property (p_romless)
		else $error("write strobe not forced in romless variant");

	// untouched select port: bits 0,1 pulled up, bit 2 pulled down
	property p_selReset;
		!selTouched |-> selPortOeN == 3'h7 && selPortPullUp == 2'h3 && selPortPullDown;
	endproperty
	a_selReset: assert property (p_selReset)
		else $error("select port left its reset state unprompted");

	// area strobe mode forwards the select line
	property p_areaSel;
		selectPortFunction[2] |=> selPortOut[2] == $past(areaSelectN[2]) && !selPortOeN[2];
	endproperty
	a_areaSel: assert property (p_areaSel)
		else $error("area strobe not on the pin");

	// select port upper bits read as ones
	property p_selUpper;
		busReq.rd && busReq.addr == `MIO_OFF_SEL_LATCH |=> rdData[7:3] == 5'h1f;
	endproperty
	a_selUpper: assert property (p_selUpper)
		else $error("select port upper bits not one");

	// analog-shared port returns pin levels
	sequence s_analogRead;
		busReq.rd && busReq.addr == `MIO_OFF_ANALOG;
	endsequence
	property p_analogRead;
		s_analogRead |=> rdData == $past(analogPortInput);
	endproperty
	a_analogRead: assert property (p_analogRead)
		else $error("analog port read wrong");

	// driven address port bits read back their latch, whatever the other bits do
	property p_readLatch;
		busReq.rd && busReq.addr == `MIO_OFF_ADDR_LATCH
			|=> (rdData & $past(addrDrive)) == ($past(addressPortLatch) & $past(addrDrive));
	endproperty
	a_readLatch: assert property (p_readLatch)
		else $error("driven port does not read its latch");

endmodule

// >>> pkg/mio_consts.svh
/*
 * constants of the multiplexed port block: register offsets, reset
 * values and field positions.
 * assumes: included by its bare name by the design.
 */
`ifndef MIO_CONSTS_SVH
`define MIO_CONSTS_SVH

// register offsets on the plain register port
`define MIO_OFF_ADDR_LATCH 8'h06
`define MIO_OFF_CTRL_LATCH 8'h07
`define MIO_OFF_ADDR_DIR 8'h08
`define MIO_OFF_ADDR_FUNC 8'h09
`define MIO_OFF_CTRL_DIR 8'h0a
`define MIO_OFF_CTRL_FUNC 8'h0b
`define MIO_OFF_SEL_LATCH 8'h0c
`define MIO_OFF_ANALOG 8'h0d
`define MIO_OFF_SEL_DIR 8'h0e
`define MIO_OFF_SEL_FUNC 8'h0f

// reset values
`define MIO_RST_ADDR_LATCH 8'h00
`define MIO_RST_CTRL_LATCH 8'hff
`define MIO_RST_SEL_LATCH 3'h3
`define MIO_RST_CFG8 8'h00
`define MIO_RST_CFG3 3'h0
`define MIO_RST_RDATA 8'h00

// field positions and fixed read values
`define MIO_RD_BIT 0
`define MIO_WR_BIT 1
`define MIO_HIGH_ADDR_LSB 16
`define MIO_SEL_UNUSED 5'h1f

`endif

// >>> pkg/mio_pkg.sv
/*
 * types of the multiplexed port block.
 * assumes: nothing beyond a SystemVerilog compiler.
 */
package mio_pkg;

	// one register port request, as the master drives it
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} mio_busreq_t;

	// per-bit mode of the address-capable port
	typedef enum logic [1:0] {
		AM_INPUT,
		AM_OUTPUT,
		AM_LOW_ADDR,
		AM_HIGH_ADDR
	} mio_amode_e_t;

endpackage

// >>> test/mio_pin_model.sv
/*
 * far-side model of the port pins: external memory and peripherals
 * that may drive undriven pins, plus the on-chip pull resistors.
 * assumes: pin controls come from the port block on mclk; the bench
 * sets extVal/extEn just after a rising edge.
 */
`timescale 1ns/100ps

module mio_pin_model (
	input wire logic mclk,
	input wire logic [7:0] addrOut,
	input wire logic [7:0] addrOeN,
	input wire logic [7:0] addrPullDown,
	input wire logic [7:0] ctrlOut,
	input wire logic [7:0] ctrlOeN,
	input wire logic [7:0] ctrlPullUp,
	input wire logic [2:0] selOut,
	input wire logic [2:0] selOeN,
	input wire logic [1:0] selPullUp,
	input wire logic selPullDown,
	input wire logic [7:0] extVal,
	input wire logic [7:0] extEn,
	output logic [7:0] addrIn,
	output logic [7:0] ctrlIn,
	output logic [2:0] selIn
);
	logic [7:0] lastA; // previous levels, used when a pin floats
	logic [7:0] lastC;
	logic [7:0] lastS;
	logic [7:0] selWide; // select port padded to eight bits

	////////////////////////////////////////////////////////////////
	// wire level: port drive wins, then the far side, then pulls;
	// a floating pin flips every cycle so no settled guess can pass
	function automatic logic [7:0] level(input logic [7:0] o, oeN, pu, pd, last,
			ev, en);
		return (~oeN & o) | (oeN & en & ev) | (oeN & ~en & (pu | (~pd & ~last)));
	endfunction

	// levels of the three ports
	always_comb begin
		addrIn = level(addrOut, addrOeN, 8'h00, addrPullDown, lastA, extVal, extEn);
		ctrlIn = level(ctrlOut, ctrlOeN, ctrlPullUp, 8'h00, lastC, extVal, extEn);
		selWide = level({5'h00, selOut}, {5'h1f, selOeN}, {6'h00, selPullUp},
			{5'h00, selPullDown, 2'h0}, lastS, extVal, extEn);
		selIn = selWide[2:0];
	end

	// remember the last level of each pin
	always_ff @(posedge mclk) begin
		lastA <= addrIn;
		lastC <= ctrlIn;
		lastS <= selWide;
	end
endmodule

// >>> test/testbench.sv
/*
 * self-checking bench of the multiplexed port block: register port
 * master, cpu-side stimulus and far-side pin model.
 * assumes: design and pin model compiled first; one clock mclk.
 */
`timescale 1ns/100ps

module testbench
	import mio_pkg::*;
;
	logic mclk, rstn;
	mio_busreq_t busReq; // register port request
	logic [7:0] rdData;
	logic [23:0] cpuAddr;
	logic cpuRdN, cpuWrN, extAccess, romlessPin, selPortPullDown, wasRd;
	logic [2:0] areaSelectN, selPortIn, selPortOut, selPortOeN;
	logic [7:2] ctrlAltOut;
	logic [7:0] addrPortIn, addrPortOut, addrPortOeN, addrPortPullDown;
	logic [7:0] ctrlPortIn, ctrlPortOut, ctrlPortOeN, ctrlPortPullUp;
	logic [1:0] selPortPullUp;
	logic [7:0] analogPortIn, extVal, extEn, v, e, d, f, m, lat;
	logic [7:0] expQ[$]; // expected read data, oldest first
	logic [31:0] seed;
	int bad_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	integer i;

	mio_ports dut (.mclk(mclk), .rstn(rstn), .busReq(busReq), .rdData(rdData),
		.cpuAddr(cpuAddr), .cpuRdN(cpuRdN), .cpuWrN(cpuWrN), .extAccess(extAccess),
		.areaSelectN(areaSelectN), .ctrlAltOut(ctrlAltOut), .romlessPin(romlessPin),
		.addrPortIn(addrPortIn), .addrPortOut(addrPortOut), .addrPortOeN(addrPortOeN),
		.addrPortPullDown(addrPortPullDown), .ctrlPortIn(ctrlPortIn),
		.ctrlPortOut(ctrlPortOut), .ctrlPortOeN(ctrlPortOeN),
		.ctrlPortPullUp(ctrlPortPullUp), .selPortIn(selPortIn), .selPortOut(selPortOut),
		.selPortOeN(selPortOeN), .selPortPullUp(selPortPullUp),
		.selPortPullDown(selPortPullDown), .analogPortIn(analogPortIn));

	mio_pin_model pins (.mclk(mclk), .addrOut(addrPortOut), .addrOeN(addrPortOeN),
		.addrPullDown(addrPortPullDown), .ctrlOut(ctrlPortOut), .ctrlOeN(ctrlPortOeN),
		.ctrlPullUp(ctrlPortPullUp), .selOut(selPortOut), .selOeN(selPortOeN),
		.selPullUp(selPortPullUp), .selPullDown(selPortPullDown), .extVal(extVal),
		.extEn(extEn), .addrIn(addrPortIn), .ctrlIn(ctrlPortIn), .selIn(selPortIn));

	////////////////////////////////////////////////////////////////
	// clock and cycle ceiling; the whole run needs well under 1000
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [7:0] rnd();
		seed = {seed[30:0], ^(seed & 32'h80200003)};
		return seed[7:0];
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one bus cycle; the whole request changes once, just after an edge
	task automatic op(input logic [7:0] a, dat, input logic w, r);
		busReq <= '{addr: a, wdata: dat, wr: w, rd: r};
		@(posedge mclk);
	endtask

	task automatic wr(input logic [7:0] a, dat);
		op(a, dat, 1'b1, 1'b0);
	endtask

	task automatic rd(input logic [7:0] a, exp);
		expQ.push_back(exp);
		op(a, 8'h00, 1'b0, 1'b1);
	endtask

	// idle cycles, then step past the edge so registered outputs settle
	task automatic look(input int n);
		repeat (n) op(8'h00, 8'h00, 1'b0, 1'b0);
		#1;
	endtask

	task print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// read data stands only in the cycle after the strobe
	always @(posedge mclk) begin
		wasRd = busReq.rd;
		#1;
		if (wasRd === 1'b1)
			chk(32'(rdData), 32'(expQ.pop_front()));
	end

	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		busReq = '0;
		cpuAddr = 24'h000000;
		cpuRdN = 1'b1;
		cpuWrN = 1'b1;
		extAccess = 1'b0;
		areaSelectN = 3'h7;
		ctrlAltOut = 6'h00;
		romlessPin = 1'b0;
		analogPortIn = 8'h00;
		extVal = 8'h00;
		extEn = 8'h00;
		rstn = 1'b0;
		seed = 32'h7e1b5ed7;
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		#1;
		chk(32'({addrPortOut, addrPortOeN, addrPortPullDown}), 32'h0000ffff);
		chk(32'({ctrlPortOut, ctrlPortOeN, ctrlPortPullUp}), 32'h00fffcfc);
		chk(32'({selPortOut, selPortOeN, selPortPullUp, selPortPullDown}), 32'h000000ff);
		@(posedge mclk);
		look(6);
		@(posedge mclk);
		// back-to-back reads of the reset state; pulls set the pin levels
		rd(8'h06, 8'h00);
		rd(8'h08, 8'h00);
		rd(8'h09, 8'h00);
		rd(8'h07, 8'hff);
		rd(8'h0c, 8'hfb);
		rd(8'h0d, 8'h00);
		rd(8'h20, 8'h00);
		// latch switches pull-downs; written whole, never read back
		v = rnd();
		wr(8'h06, v);
		look(1);
		chk(32'(addrPortPullDown), {24'h000000, ~v});
		@(posedge mclk);
		e = rnd();
		extVal <= e;
		extEn <= 8'hff;
		look(5);
		@(posedge mclk);
		rd(8'h06, e);
		// all four modes at once; direction written before function
		lat = rnd();
		cpuAddr <= seed[31:8];
		d = 8'h55;
		f = 8'hc3;
		m = d | f;
		wr(8'h06, lat);
		wr(8'h08, d);
		wr(8'h09, f);
		look(1);
		chk(32'(addrPortOut & m), 32'((~f & d & lat) | (f & ~d & cpuAddr[7:0])
			| (f & d & cpuAddr[23:16])));
		chk(32'(addrPortOeN), {24'h000000, ~m});
		chk(32'(addrPortPullDown), {24'h000000, ~lat});
		@(posedge mclk);
		look(5);
		@(posedge mclk);
		rd(8'h06, (m & lat) | (~m & e));
		// control port: strobe gating by latch and external access
		v = rnd();
		ctrlAltOut <= v[7:2];
		wr(8'h0a, 8'hfc);
		wr(8'h0b, 8'hff);
		for (i = 0; i < 8; i++) begin
			cpuRdN <= i[0];
			cpuWrN <= ~i[0];
			extAccess <= i[1];
			wr(8'h07, {7'h7f, i[2]});
			look(1);
			chk(32'(ctrlPortOut[0]), 32'((!i[2] || i[1]) ? i[0] : 1'b1));
			chk(32'({ctrlPortOut[7:1], ctrlPortOeN}), 32'({v[7:2], ~i[0], 8'h00}));
			@(posedge mclk);
		end
		// strap forces both strobes whatever the function bits say
		romlessPin <= 1'b1;
		cpuRdN <= 1'b1;
		cpuWrN <= 1'b0;
		wr(8'h0b, 8'h00);
		wr(8'h07, 8'hfc);
		look(6);
		chk(32'(ctrlPortOut[1:0]), 32'h1);
		@(posedge mclk);
		romlessPin <= 1'b0;
		look(6);
		chk(32'(ctrlPortOut[1:0]), 32'h0);
		@(posedge mclk);
		// select port: area strobes, then plain outputs
		v = rnd();
		areaSelectN <= v[2:0];
		wr(8'h0f, 8'h07);
		look(1);
		chk(32'({selPortOut, selPortOeN}), 32'({v[2:0], 3'h0}));
		@(posedge mclk);
		wr(8'h0f, 8'h00);
		wr(8'h0e, 8'h07);
		wr(8'h0c, 8'h05);
		look(1);
		chk(32'({selPortOut, selPortOeN, selPortPullUp, selPortPullDown}), 32'h140);
		@(posedge mclk);
		rd(8'h0c, 8'hfd);
		// analog-shared port ignores writes and shows pin levels
		v = rnd();
		analogPortIn <= v;
		wr(8'h0d, ~v);
		look(5);
		@(posedge mclk);
		rd(8'h0d, v);
		look(2);
		print_verdict();
	end
endmodule
